// >>> rtl/dac_serial_map.vh
// Constants for the serial-load DAC front end
`ifndef DAC_SERIAL_MAP_VH
`define DAC_SERIAL_MAP_VH
`define FRAME_BITS      16
`define COUNT_W         5
`define COUNT_ZERO      5'h00
`define COUNT_ONE       5'h01
`define COUNT_LAST      5'h10
`define CODE_W          12
`define CODE_HI         13
`define CODE_LO         2
`define MODE_HI         15
`define MODE_LO         14
`define SHIFT_RESET     16'h0000
`define CODE_RESET      12'h000
`define MODE_NORMAL     2'h0
`define MODE_PD_1K      2'h1
`define MODE_PD_100K    2'h2
`define MODE_PD_TRI     2'h3
`define ST_IDLE         2'h0
`define ST_SHIFT        2'h1
`define ST_DONE         2'h2
`endif

// >>> rtl/sync_edge.v
// Two-flop synchroniser with edge detection on the settled copy
`timescale 1ns/1ps
module sync_edge (
  input  wire clk,
  input  wire arst_n,
  input  wire asyncIn,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg settled_ff;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff    <= 1'b1;
      settled_ff <= 1'b1;
      level      <= 1'b1;
    end else begin
      meta_ff    <= asyncIn;
      settled_ff <= meta_ff;
      level      <= settled_ff;
    end
  end

  assign rise = settled_ff & ~level;
  assign fall = ~settled_ff & level;
endmodule

// >>> rtl/dac_serial_load_interface.v
// Serial load front end of a single-channel voltage-output DAC
// Summary of operation
// - Data sampled into 16-bit shift register on falling serial clock edges.
// - Sixteenth falling edge captures last bit and executes the word.
// - First two bits shifted in select normal or power-down mode.
// - Twelve bits after control bits form the code, loaded on sixteenth edge.
// - Final two bits of the frame are ignored.
// - Early frame select rise resets shifter and discards frame.
// - Reset clears code to zero until first complete frame.
// - Code is straight unsigned binary.
// - Mode 00 normal, 01 1k to ground, 10 100k, 11 three-state.
// - Power-down frames still load their twelve code bits into the stored code.
`timescale 1ns/1ps
`include "dac_serial_map.vh"
module dac_serial_load_interface (
  input  wire                clk,
  input  wire                arst_n,
  input  wire                frameSelN,
  input  wire                serialClk,
  input  wire                serial_data_in,
  output reg  [`CODE_W-1:0]  dacCode_ff,
  output reg                 mode_bit_high,
  output reg                 mode_bit_low,
  output reg                 powerDown1k_ff,
  output reg                 powerDown100k_ff,
  output reg                 outputTri_ff,
  output reg                 loadPulse_ff,
  output reg                 abortPulse_ff,
  output reg                 busy_ff
);
  // ==========================================================
  // Input synchronisers
  wire selLevel;
  wire selRise;
  wire selFall;
  wire clkFall;
  reg  dataMeta_ff;
  reg  dataSync_ff;
  reg  dataDly_ff;

  sync_edge selSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (frameSelN),
    .level   (selLevel),
    .rise    (selRise),
    .fall    (selFall)
  );

  sync_edge sclkSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (serialClk),
    .level   (),
    .rise    (),
    .fall    (clkFall)
  );

  // Data delayed to line up with the clock path's extra stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataMeta_ff <= 1'b0;
      dataSync_ff <= 1'b0;
      dataDly_ff  <= 1'b0;
    end else begin
      dataMeta_ff <= serial_data_in;
      dataSync_ff <= dataMeta_ff;
      dataDly_ff  <= dataSync_ff;
    end
  end

  // ==========================================================
  // Frame state machine and shifter
  reg [1:0]             state_ff;
  reg [1:0]             nxt_state;
  reg [`FRAME_BITS-1:0] shift_ff;
  reg [`FRAME_BITS-1:0] nxt_shift;
  reg [`COUNT_W-1:0]    count_ff;
  reg [`COUNT_W-1:0]    nxt_count;
  reg                   execute;
  reg                   abort;
  wire [`FRAME_BITS-1:0] shifted;

  // MSB-first: new bit enters at the bottom
  assign shifted = {shift_ff[`FRAME_BITS-2:0], dataDly_ff};

  always @* begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_count = count_ff;
    execute   = 1'b0;
    abort     = 1'b0;
    case (state_ff)
      `ST_IDLE: begin
        if (selFall) begin
          nxt_state = `ST_SHIFT;
          nxt_shift = `SHIFT_RESET;
          nxt_count = `COUNT_ZERO;
        end
      end
      `ST_SHIFT: begin
        if (selRise) begin
          nxt_state = `ST_IDLE;
          nxt_shift = `SHIFT_RESET;
          nxt_count = `COUNT_ZERO;
          abort     = 1'b1;
        end else if (clkFall && !selLevel) begin
          nxt_shift = shifted;
          nxt_count = count_ff + `COUNT_ONE;
          if (count_ff + `COUNT_ONE == `COUNT_LAST) begin
            execute   = 1'b1;
            nxt_state = `ST_DONE;
          end
        end
      end
      `ST_DONE: begin
        // Clocks ignored until frame select goes high again
        if (selRise || selLevel) begin
          nxt_state = `ST_IDLE;
          nxt_count = `COUNT_ZERO;
        end
      end
      default: begin
        nxt_state = `ST_IDLE;
        nxt_count = `COUNT_ZERO;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= `ST_IDLE;
      shift_ff <= `SHIFT_RESET;
      count_ff <= `COUNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
    end
  end

  // ==========================================================
  // Mode decode
  wire [1:0] nxt_mode;
  reg        nxt_powerDown1k;
  reg        nxt_powerDown100k;
  reg        nxt_outputTri;

  assign nxt_mode = {shifted[`MODE_HI], shifted[`MODE_LO]};

  // At most one flag set (none in normal mode) so the output stage never sees two networks at once
  always @* begin
    nxt_powerDown1k   = 1'b0;
    nxt_powerDown100k = 1'b0;
    nxt_outputTri     = 1'b0;
    case (nxt_mode)
      `MODE_NORMAL: begin
        nxt_outputTri = 1'b0;
      end
      `MODE_PD_1K: begin
        nxt_powerDown1k = 1'b1;
      end
      `MODE_PD_100K: begin
        nxt_powerDown100k = 1'b1;
      end
      `MODE_PD_TRI: begin
        nxt_outputTri = 1'b1;
      end
      default: begin
        nxt_outputTri = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // DAC register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dacCode_ff <= `CODE_RESET;
    end else if (execute) begin
      // Code is loaded in every mode, so a power-down frame replaces the last value
      dacCode_ff <= shifted[`CODE_HI:`CODE_LO];
    end
  end

  // ==========================================================
  // Operating mode
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_bit_high    <= 1'b0;
      mode_bit_low     <= 1'b0;
      powerDown1k_ff   <= 1'b0;
      powerDown100k_ff <= 1'b0;
      outputTri_ff     <= 1'b0;
    end else if (execute) begin
      mode_bit_high    <= nxt_mode[1];
      mode_bit_low     <= nxt_mode[0];
      powerDown1k_ff   <= nxt_powerDown1k;
      powerDown100k_ff <= nxt_powerDown100k;
      outputTri_ff     <= nxt_outputTri;
    end
  end

  // ==========================================================
  // Frame status
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loadPulse_ff  <= 1'b0;
      abortPulse_ff <= 1'b0;
      busy_ff       <= 1'b0;
    end else begin
      loadPulse_ff  <= execute;
      abortPulse_ff <= abort;
      busy_ff       <= (nxt_state == `ST_SHIFT);
    end
  end
endmodule

// >>> verif/dac_serial_load_interface_properties.sv
// Port-level assertions for the DAC serial load front end
`timescale 1ns/1ps
module dac_serial_load_interface_properties (
  input wire        clk,
  input wire        arst_n,
  input wire        frameSelN,
  input wire        serialClk,
  input wire        serial_data_in,
  input wire [11:0] dacCode_ff,
  input wire        mode_bit_high,
  input wire        mode_bit_low,
  input wire        powerDown1k_ff,
  input wire        powerDown100k_ff,
  input wire        outputTri_ff,
  input wire        loadPulse_ff,
  input wire        abortPulse_ff,
  input wire        busy_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence parkAfterLoad;
    loadPulse_ff ##1 (!frameSelN) [*8];
  endsequence
  chk_mode_flags:
    assert property ({outputTri_ff, powerDown100k_ff, powerDown1k_ff,
      !(mode_bit_high | mode_bit_low)} == 4'h1 << {mode_bit_high, mode_bit_low})
      else $error("mode flags wrong");
  chk_code_hold:
    assert property (!loadPulse_ff |-> $stable(dacCode_ff)) else $error("code moved");
  chk_mode_hold:
    assert property (!loadPulse_ff |-> $stable({mode_bit_high, mode_bit_low}))
      else $error("mode moved");
  chk_load_once:
    assert property (loadPulse_ff |=> !loadPulse_ff) else $error("load pulse long");
  chk_load_ends:
    assert property (loadPulse_ff |-> !busy_ff && $past(busy_ff)) else $error("load odd");
  chk_abort_ends:
    assert property (abortPulse_ff |-> !loadPulse_ff && $past(busy_ff)) else $error("abort odd");
  chk_frame_start:
    assert property ($fell(frameSelN) && !busy_ff |-> ##[1:5] busy_ff) else $error("no start");
  chk_no_rerun:
    assert property (parkAfterLoad |-> !busy_ff && !loadPulse_ff) else $error("reran");
endmodule
bind dac_serial_load_interface dac_serial_load_interface_properties u_chk (
  .clk              (clk),
  .arst_n           (arst_n),
  .frameSelN        (frameSelN),
  .serialClk        (serialClk),
  .serial_data_in   (serial_data_in),
  .dacCode_ff       (dacCode_ff),
  .mode_bit_high    (mode_bit_high),
  .mode_bit_low     (mode_bit_low),
  .powerDown1k_ff   (powerDown1k_ff),
  .powerDown100k_ff (powerDown100k_ff),
  .outputTri_ff     (outputTri_ff),
  .loadPulse_ff     (loadPulse_ff),
  .abortPulse_ff    (abortPulse_ff),
  .busy_ff          (busy_ff)
);

// >>> verif/host_serial_master.sv
// Behavioural host that sends serial write frames
`timescale 1ns/1ps
module host_serial_master (
  output logic frameSelN,
  output logic serialClk,
  output logic serial_data_in
);
  initial begin
    frameSelN = 1'b1;
    serialClk = 1'b1;
    serial_data_in = 1'b0;
  end
  // Raising select first lets a parked-low line make a fresh fall
  task automatic xfer(input logic [15:0] w, input int n, input bit park);
    frameSelN = 1'b1;
    #40 frameSelN = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      serial_data_in = w[15 - (i % 16)];
      #32 serialClk = 1'b0;
      #32 serialClk = 1'b1;
    end
    #32 frameSelN = !park;
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the DAC serial load front end
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  wire [11:0] dacCode_ff;
  wire frameSelN, serialClk, serial_data_in, mode_bit_high, mode_bit_low, busy_ff;
  wire powerDown1k_ff, powerDown100k_ff, outputTri_ff, loadPulse_ff, abortPulse_ff;
  wire [15:0] outWord = {2'h0, mode_bit_high, mode_bit_low, dacCode_ff};
  wire [15:0] flagWord = {12'h000, busy_ff, outputTri_ff, powerDown100k_ff, powerDown1k_ff};
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] nLoad = 16'h0000;
  logic [15:0] nAbort = 16'h0000;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    nLoad <= nLoad + loadPulse_ff;
    nAbort <= nAbort + abortPulse_ff;
  end
  dac_serial_load_interface u_dac_serial_load_interface (
    .clk              (clk),
    .arst_n           (arst_n),
    .frameSelN        (frameSelN),
    .serialClk        (serialClk),
    .serial_data_in   (serial_data_in),
    .dacCode_ff       (dacCode_ff),
    .mode_bit_high    (mode_bit_high),
    .mode_bit_low     (mode_bit_low),
    .powerDown1k_ff   (powerDown1k_ff),
    .powerDown100k_ff (powerDown100k_ff),
    .outputTri_ff     (outputTri_ff),
    .loadPulse_ff     (loadPulse_ff),
    .abortPulse_ff    (abortPulse_ff),
    .busy_ff          (busy_ff)
  );
  host_serial_master u_host_serial_master (
    .frameSelN      (frameSelN),
    .serialClk      (serialClk),
    .serial_data_in (serial_data_in)
  );
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_reset(input bit pulse);
    if (pulse) begin
      @(posedge clk);
      #1 arst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 arst_n = 1'b1;
    end
    repeat (4) @(posedge clk);
    #1;
    compare(outWord, 16'h0000);
    compare(flagWord, 16'h0000);
    $display("test reset done");
  endtask
  task automatic test_modes;
    u_host_serial_master.xfer(16'h2a5f, 16, 0);
    compare(outWord, 16'h0a97);
    compare(flagWord, 16'h0000);
    for (int m = 1; m < 4; m++) begin
      u_host_serial_master.xfer({m[1:0], 12'ha97, 2'h2}, 16, 0);
      compare(outWord, {2'h0, m[1:0], 12'ha97});
      compare(flagWord, 16'h0001 << (m - 1));
    end
    $display("test modes done");
  endtask
  // First partial frame is left open, so the next raise aborts it
  task automatic test_abort;
    u_host_serial_master.xfer(16'h0123, 10, 1);
    compare(flagWord, 16'h000c);
    u_host_serial_master.xfer(16'h0123, 10, 0);
    #50;
    compare(outWord, 16'h3a97);
    compare(flagWord, 16'h0004);
    compare(nAbort, 16'h0002);
    $display("test abort done");
  endtask
  // Two frames' worth of clocks: a rerun would load a second time
  task automatic test_park;
    u_host_serial_master.xfer(16'h7ffc, 32, 1);
    compare(outWord, 16'h1fff);
    compare(nLoad, 16'h0005);
    u_host_serial_master.xfer(16'h0004, 16, 0);
    compare(outWord, 16'h0001);
    compare(flagWord, 16'h0000);
    compare(nLoad, 16'h0006);
    $display("test park done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    test_reset(0);
    test_modes;
    test_abort;
    test_park;
    test_reset(1);
    complete_run;
  end
  // Watchdog: a hang counts as a mismatch
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
endmodule
